// >>> inc/uoesc_pkg.sv
// Constants and carrier types for the OUT endpoint status and control block.
// Assumes a byte-wide register port and a serial engine on the same clock.
package uoesc_pkg;

   // Register byte addresses on the plain register port
   localparam logic [7:0] ADDR_CTL_LOW = 8'h00;
   localparam logic [7:0] ADDR_CTL_HIGH = 8'h01;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h02;
   localparam logic [7:0] ADDR_INT_MASK = 8'h03;

   // Control low byte fields
   localparam int BIT_TOGGLE_CLEAR = 7;
   localparam int BIT_STALL_SENT = 6;
   localparam int BIT_STALL_REQUEST = 5;
   localparam int BIT_DISCARD = 4;
   localparam int BIT_DATA_ERROR = 3;
   localparam int BIT_OVERRUN = 2;
   localparam int BIT_BUFFER_FULL = 1;
   localparam int BIT_PACKET_READY = 0;

   // Control high byte fields
   localparam int BIT_DOUBLE_BUFFER = 7;
   localparam int BIT_ISO_MODE = 6;

   // Interrupt status and mask fields
   localparam int BIT_INT_PACKET_READY = 0;
   localparam int BIT_INT_STALL_SENT = 1;
   localparam int BIT_INT_OVERRUN = 2;
   localparam int INT_WIDTH = 3;

   // Reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [INT_WIDTH-1:0] RESET_INT = 3'h0;
   localparam logic [9:0] RESET_PTR = 10'h000;

   // Packet slots in the OUT FIFO
   localparam int SLOT_COUNT = 2;

   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_discard = 2'b10
   } uoesc_state_t;

   // Packet completion from the serial engine
   typedef struct packed {
      logic valid;
      logic crc_error;
      logic stuff_error;
   } uoesc_rx_t;

   // Handshake answer to an OUT token
   typedef struct packed {
      logic valid;
      logic stall;
      logic nak;
      logic ack;
   } uoesc_hs_t;

endpackage

// >>> verilog/uoesc_pkt_queue.sv
// Occupancy and per-packet error tracking for the two OUT FIFO packet slots.
// Assumes push is never raised while full and pop only counts when a packet is held.
`timescale 1ns/1ps
`default_nettype none

module uoesc_pkt_queue
   import uoesc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic push,
   input wire logic push_err,
   input wire logic pop,
   input wire logic double_buffer,
   output logic [1:0] count,
   output logic head_err,
   output logic full
);

   logic [SLOT_COUNT-1:0] err_slot;
   logic [SLOT_COUNT-1:0] next_err_slot;
   logic head;
   logic next_head;
   logic [1:0] next_count;
   logic push_ok;
   logic pop_ok;
   logic tail;

   always_comb begin
      push_ok = push && (count != 2'h2);
      pop_ok = pop && (count != 2'h0);
      tail = head ^ (count == 2'h1);
      next_err_slot = err_slot;
      for (int i = 0; i < SLOT_COUNT; i++) begin
         if (push_ok && (tail == i[0])) begin
            next_err_slot[i] = push_err;
         end
      end
      next_head = pop_ok ? ~head : head;
      next_count = count;
      if (push_ok && !pop_ok) begin
         next_count = count + 2'h1;
      end else if (pop_ok && !push_ok) begin
         next_count = count - 2'h1;
      end
      head_err = err_slot[head];
      full = double_buffer ? (count == 2'h2) : (count != 2'h0);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         err_slot <= '0;
         head <= 1'b0;
         count <= 2'h0;
      end else begin
         err_slot <= next_err_slot;
         head <= next_head;
         count <= next_count;
      end
   end

endmodule

`default_nettype wire

// >>> verilog/uoesc_top.sv
// Status and control for one USB OUT endpoint receive FIFO.
// Assumes the serial engine and FIFO access logic run on clk; firmware uses the register port.
// Function
// - While the stall request bit is one every OUT token is answered with STALL, and clearing it ends that.
// - Writing one to the discard bit drops the oldest unread packet, resets the read pointer and clears packet ready.
// - The discard bit returns to zero by itself when the discard is done, so firmware can poll it.
// - A CRC or bit-stuffing fault in isochronous mode sets data error, which clears with packet ready.
// - A packet arriving to a full FIFO in isochronous mode sets overrun, which stays until firmware clears it.
// - Buffer full reads one with two packets held under double buffering, or one packet without it.
// - Packet ready is set when a packet is held and firmware clears it after unloading the packet.
// - Each STALL sent sets stall sent and raises an interrupt, and firmware clears stall sent.
// - With two packets queued, packet ready is set again right after firmware clears it, with a new interrupt.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uoesc_top
   import uoesc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic out_token,
   input wire uoesc_rx_t rx_evt,
   input wire logic fifo_rd,
   output uoesc_hs_t hs,
   output logic [9:0] rd_ptr,
   output logic toggle_clear,
   output logic irq
);

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   uoesc_state_t state;
   uoesc_state_t next_state;
   logic stall_request;
   logic next_stall_request;
   logic stall_sent;
   logic next_stall_sent;
   logic overrun;
   logic next_overrun;
   logic packet_ready;
   logic next_packet_ready;
   logic double_buffer;
   logic next_double_buffer;
   logic iso_mode;
   logic next_iso_mode;
   logic [9:0] next_rd_ptr;
   logic next_toggle_clear;
   uoesc_hs_t next_hs;
   logic [INT_WIDTH-1:0] int_status;
   logic [INT_WIDTH-1:0] next_int_status;
   logic [INT_WIDTH-1:0] int_mask;
   logic [INT_WIDTH-1:0] next_int_mask;
   logic [INT_WIDTH-1:0] events;
   logic next_irq;
   logic [7:0] next_reg_rdata;
   logic [7:0] ctl_low_view;
   logic wr_ctl;
   logic wr_high;
   logic discard_req;
   logic ready_clear;
   logic stall_evt;
   logic overrun_evt;
   logic push;
   logic pop;
   logic [1:0] count;
   logic head_err;
   logic full;

   uoesc_pkt_queue u_queue (
      .clk(clk),
      .resetn(resetn),
      .push(push),
      .push_err(iso_mode && (rx_evt.crc_error || rx_evt.stuff_error)),
      .pop(pop),
      .double_buffer(double_buffer),
      .count(count),
      .head_err(head_err),
      .full(full)
   );

   // Endpoint control and packet flow
   always_comb begin
      wr_ctl = reg_wr && hit(reg_addr, ADDR_CTL_LOW);
      wr_high = reg_wr && hit(reg_addr, ADDR_CTL_HIGH);
      // A write that asks for a discard ignores its own packet ready bit, so one write pops once
      discard_req = wr_ctl && reg_wdata[BIT_DISCARD] && (state == st_idle);
      ready_clear = wr_ctl && !reg_wdata[BIT_DISCARD] && !reg_wdata[BIT_PACKET_READY] && packet_ready;
      stall_evt = out_token && stall_request;
      overrun_evt = rx_evt.valid && !stall_request && full && iso_mode;
      // Stalled or refused packets never reach the queue
      push = rx_evt.valid && !stall_request && !full;
      pop = ready_clear || (state == st_discard);

      next_state = state;
      unique case (state)
         st_idle: begin
            if (discard_req) begin
               next_state = st_discard;
            end
         end
         st_discard: begin
            next_state = st_idle;
         end
      endcase

      next_stall_request = wr_ctl ? reg_wdata[BIT_STALL_REQUEST] : stall_request;
      next_stall_sent = stall_sent;
      if (wr_ctl && !reg_wdata[BIT_STALL_SENT]) begin
         next_stall_sent = 1'b0;
      end
      if (stall_evt) begin
         next_stall_sent = 1'b1;
      end
      next_overrun = overrun;
      if (wr_ctl && !reg_wdata[BIT_OVERRUN]) begin
         next_overrun = 1'b0;
      end
      if (overrun_evt) begin
         next_overrun = 1'b1;
      end
      // Rises again one cycle after a pop while a second packet waits
      next_packet_ready = pop ? 1'b0 : (count != 2'h0);

      next_double_buffer = wr_high ? reg_wdata[BIT_DOUBLE_BUFFER] : double_buffer;
      next_iso_mode = wr_high ? reg_wdata[BIT_ISO_MODE] : iso_mode;

      next_rd_ptr = rd_ptr;
      if (pop) begin
         next_rd_ptr = RESET_PTR;
      end else if (fifo_rd) begin
         next_rd_ptr = rd_ptr + 10'h001;
      end
      next_toggle_clear = wr_ctl && reg_wdata[BIT_TOGGLE_CLEAR];

      // Isochronous endpoints send no handshake unless stall request is set, which still sends STALL
      next_hs.valid = out_token && (stall_request || !iso_mode);
      next_hs.stall = out_token && stall_request;
      next_hs.nak = out_token && !stall_request && !iso_mode && full;
      next_hs.ack = out_token && !stall_request && !iso_mode && !full;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= st_idle;
         stall_request <= 1'b0;
         stall_sent <= 1'b0;
         overrun <= 1'b0;
         packet_ready <= 1'b0;
         double_buffer <= 1'b0;
         iso_mode <= 1'b0;
         rd_ptr <= RESET_PTR;
         toggle_clear <= 1'b0;
         hs <= '0;
      end else begin
         state <= next_state;
         stall_request <= next_stall_request;
         stall_sent <= next_stall_sent;
         overrun <= next_overrun;
         packet_ready <= next_packet_ready;
         double_buffer <= next_double_buffer;
         iso_mode <= next_iso_mode;
         rd_ptr <= next_rd_ptr;
         toggle_clear <= next_toggle_clear;
         hs <= next_hs;
      end
   end

   // Interrupt status, mask and read port
   always_comb begin
      events = '0;
      events[BIT_INT_PACKET_READY] = next_packet_ready && !packet_ready;
      events[BIT_INT_STALL_SENT] = stall_evt;
      events[BIT_INT_OVERRUN] = overrun_evt;
      // Set beats the clear of a read in the same cycle
      next_int_status = (reg_rd && hit(reg_addr, ADDR_INT_STATUS)) ? RESET_INT : int_status;
      next_int_status = next_int_status | events;
      next_int_mask = (reg_wr && hit(reg_addr, ADDR_INT_MASK)) ? reg_wdata[INT_WIDTH-1:0] : int_mask;
      next_irq = |(next_int_status & next_int_mask);

      ctl_low_view = RESET_BYTE;
      ctl_low_view[BIT_STALL_SENT] = stall_sent;
      ctl_low_view[BIT_STALL_REQUEST] = stall_request;
      ctl_low_view[BIT_DISCARD] = (state == st_discard);
      ctl_low_view[BIT_DATA_ERROR] = packet_ready && head_err;
      ctl_low_view[BIT_OVERRUN] = overrun;
      ctl_low_view[BIT_BUFFER_FULL] = full;
      ctl_low_view[BIT_PACKET_READY] = packet_ready;

      next_reg_rdata = RESET_BYTE;
      if (reg_rd) begin
         if (hit(reg_addr, ADDR_CTL_LOW)) begin
            next_reg_rdata = ctl_low_view;
         end else if (hit(reg_addr, ADDR_CTL_HIGH)) begin
            next_reg_rdata[BIT_DOUBLE_BUFFER] = double_buffer;
            next_reg_rdata[BIT_ISO_MODE] = iso_mode;
         end else if (hit(reg_addr, ADDR_INT_STATUS)) begin
            next_reg_rdata[INT_WIDTH-1:0] = int_status;
         end else if (hit(reg_addr, ADDR_INT_MASK)) begin
            next_reg_rdata[INT_WIDTH-1:0] = int_mask;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_status <= RESET_INT;
         int_mask <= RESET_INT;
         irq <= 1'b0;
         reg_rdata <= RESET_BYTE;
      end else begin
         int_status <= next_int_status;
         int_mask <= next_int_mask;
         irq <= next_irq;
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule

`default_nettype wire

// >>> dv/uoesc_assertions.sv
// Port assertions for the OUT endpoint status block.
// Bound into uoesc_top; mirrors only the stall and mask bits firmware writes.
`timescale 1ns/1ps
`default_nettype none
module uoesc_assertions
   import uoesc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic out_token,
   input wire uoesc_hs_t hs,
   input wire logic fifo_rd,
   input wire logic [9:0] rd_ptr,
   input wire logic irq
);
   logic stall, next_stall;
   logic [INT_WIDTH-1:0] mask, next_mask;
   wire logic ctl_wr = reg_wr && reg_addr == ADDR_CTL_LOW;
   wire logic ctl_rd = reg_rd && reg_addr == ADDR_CTL_LOW;
   always_comb begin
      next_stall = ctl_wr ? reg_wdata[BIT_STALL_REQUEST] : stall;
      next_mask = (reg_wr && reg_addr == ADDR_INT_MASK) ? reg_wdata[INT_WIDTH-1:0] : mask;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stall <= 1'b0;
         mask <= RESET_INT;
      end else begin
         stall <= next_stall;
         mask <= next_mask;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   stall_answer_a: assert property (out_token && stall |=> hs.valid && hs.stall)
      else $error("stall request not answered with STALL");
   stall_release_a: assert property (out_token && !stall |=> !hs.stall)
      else $error("STALL sent without stall request");
   answer_timing_a: assert property (hs.valid |-> $past(out_token))
      else $error("handshake without token one cycle before");
   discard_ptr_a: assert property (ctl_wr && reg_wdata[BIT_DISCARD] ##1 !fifo_rd |=> rd_ptr == RESET_PTR)
      else $error("discard did not reset read pointer");
   discard_done_a: assert property (ctl_rd && !$past(ctl_wr && reg_wdata[BIT_DISCARD]) |=> !reg_rdata[BIT_DISCARD])
      else $error("discard bit still set after discard");
   data_error_a: assert property ($past(ctl_rd) && reg_rdata[BIT_DATA_ERROR] |-> reg_rdata[BIT_PACKET_READY])
      else $error("data error read without packet ready");
   stall_sent_a: assert property (out_token && stall ##1 !reg_wr ##1 ctl_rd |=> reg_rdata[BIT_STALL_SENT])
      else $error("stall sent flag not set");
   stall_irq_a: assert property (out_token && stall && mask[BIT_INT_STALL_SENT] |-> ##[1:3] irq)
      else $error("no interrupt after STALL");
endmodule
bind uoesc_top uoesc_assertions chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_token(out_token), .hs(hs),
   .fifo_rd(fifo_rd), .rd_ptr(rd_ptr), .irq(irq));
`default_nettype wire

// >>> dv/uoesc_host.sv
// Behavioural USB host issuing OUT tokens and completed packets.
// Assumes the serial engine view shares clk with the endpoint block.
`timescale 1ns/1ps
`default_nettype none
module uoesc_host
   import uoesc_pkg::*;
(
   input wire logic clk,
   output logic out_token,
   output var uoesc_rx_t rx_evt
);
   initial begin
      out_token = 1'b0;
      rx_evt = '0;
   end
   task automatic token();
      @(posedge clk) out_token <= 1'b1;
      @(posedge clk) out_token <= 1'b0;
   endtask
   task automatic packet(input logic crc, input logic stuff);
      @(posedge clk) rx_evt <= '{1'b1, crc, stuff};
      @(posedge clk) rx_evt <= '0;
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the OUT endpoint status block.
// Firmware traffic from here; host traffic through uoesc_host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import uoesc_pkg::*;
   logic clk, resetn, reg_wr, reg_rd, fifo_rd, out_token, irq, toggle_clear;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [9:0] rd_ptr;
   uoesc_rx_t rx_evt;
   uoesc_hs_t hs;
   int err_total, num_checks;
   // Rows: write flag, address, write data, expected read
   logic [24:0] rows [11] = '{25'h0_00_00_00, 25'h0_01_00_00, 25'h0_02_00_00, 25'h0_03_00_00,
      25'h1_01_ff_c0, 25'h1_01_00_00, 25'h1_03_07_07, 25'h1_20_5a_00, 25'h1_00_80_00,
      25'h1_00_20_20, 25'h1_00_00_00};
   uoesc_top uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_token(out_token), .rx_evt(rx_evt), .fifo_rd(fifo_rd),
      .hs(hs), .rd_ptr(rd_ptr), .toggle_clear(toggle_clear), .irq(irq));
   uoesc_host host (.clk(clk), .out_token(out_token), .rx_evt(rx_evt));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic final_report();
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_val(input logic [9:0] g, input logic [9:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_hs(input uoesc_hs_t e);
      @(negedge clk);
      chk_val({6'h00, hs}, {6'h00, e});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_val({2'h0, reg_rdata}, {2'h0, e});
   endtask
   task automatic rx_chk(input logic crc, input logic stuff, input logic [7:0] e);
      host.packet(crc, stuff);
      idle(3);
      rd_chk(ADDR_CTL_LOW, e);
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      final_report();
   end
   initial begin
      {resetn, reg_wr, reg_rd, fifo_rd, reg_addr, reg_wdata} = '0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
         rd_chk(rows[i][23:16], rows[i][7:0]);
      end
      // Toggle clear is a one-cycle pulse after the write
      wr(ADDR_CTL_LOW, 8'h80);
      #1 chk_val(toggle_clear, 1'b1);
      wr(ADDR_CTL_LOW, 8'h20);
      #1 chk_val(toggle_clear, 1'b0);
      host.token();
      chk_hs(4'b1100);
      rd_chk(ADDR_CTL_LOW, 8'h60);
      chk_val(irq, 1'b1);
      rd_chk(ADDR_INT_STATUS, 8'h02);
      idle(2);
      #1 chk_val(irq, 1'b0);
      wr(ADDR_CTL_LOW, 8'h00);
      host.token();
      chk_hs(4'b1001);
      wr(ADDR_CTL_HIGH, 8'h80);
      host.packet(1'b0, 1'b0);
      rx_chk(1'b0, 1'b0, 8'h03);
      rd_chk(ADDR_INT_STATUS, 8'h01);
      host.token();
      chk_hs(4'b1010);
      @(posedge clk);
      fifo_rd <= 1'b1;
      idle(3);
      fifo_rd <= 1'b0;
      #1 chk_val(rd_ptr, 10'h003);
      wr(ADDR_CTL_LOW, 8'h00);
      #1 chk_val(rd_ptr, RESET_PTR);
      idle(2);
      rd_chk(ADDR_CTL_LOW, 8'h01);
      rd_chk(ADDR_INT_STATUS, 8'h01);
      // Second packet is still unread, so discarding it is allowed
      wr(ADDR_CTL_LOW, 8'h10);
      rd_chk(ADDR_CTL_LOW, 8'h00);
      wr(ADDR_CTL_HIGH, 8'h00);
      rx_chk(1'b0, 1'b0, 8'h03);
      wr(ADDR_CTL_LOW, 8'h00);
      wr(ADDR_CTL_HIGH, 8'hc0);
      rx_chk(1'b1, 1'b0, 8'h09);
      host.token();
      chk_hs(4'b0000);
      rx_chk(1'b0, 1'b1, 8'h0b);
      rx_chk(1'b0, 1'b0, 8'h0f);
      // Writing one keeps overrun while unloading the head packet
      wr(ADDR_CTL_LOW, 8'h04);
      idle(2);
      rd_chk(ADDR_CTL_LOW, 8'h0d);
      wr(ADDR_CTL_LOW, 8'h00);
      idle(2);
      rd_chk(ADDR_CTL_LOW, 8'h00);
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      rd_chk(ADDR_CTL_HIGH, 8'h00);
      rd_chk(ADDR_INT_MASK, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
